// *** inc/mb_write_pkg.sv ***
// constants for the multi-register write command interpreter
package mb_write_pkg;
   localparam logic [7:0]  FC_WRITE_MULTI = 8'h10;
   localparam logic [7:0]  BCAST_ADDR     = 8'h00;
   localparam logic [15:0] PD_BASE        = 16'h07d0;
   localparam int          PD_COUNT       = 3;
   localparam logic [15:0] PD_COUNT_W     = 16'h0003;
   localparam int          PD_CTRL        = 0;
   localparam int          PD_SPEED       = 2;
   localparam logic [7:0]  IDX_DEV        = 8'h00;
   localparam logic [7:0]  IDX_FC         = 8'h01;
   localparam logic [7:0]  IDX_START_HI   = 8'h02;
   localparam logic [7:0]  IDX_START_LO   = 8'h03;
   localparam logic [7:0]  IDX_QTY_HI     = 8'h04;
   localparam logic [7:0]  IDX_QTY_LO     = 8'h05;
   localparam logic [7:0]  IDX_BC         = 8'h06;
   localparam logic [7:0]  IDX_DATA       = 8'h07;
   localparam logic [7:0]  IDX_MAX        = 8'hff;
   localparam logic [7:0]  CRC_LEN        = 8'h02;
   localparam logic [15:0] CRC_INIT       = 16'hffff;
   localparam logic [15:0] CRC_POLY       = 16'ha001;
   localparam logic [15:0] CRC_RESIDUE    = 16'h0000;
   localparam logic [2:0]  RSP_LAST       = 3'h7;
   localparam logic [2:0]  RSP_CRC_LO     = 3'h6;
   localparam logic [15:0] RUN_CMD        = 16'h0001;
   localparam logic [15:0] SETPOINT_FULL  = 16'h2710;
   localparam int          FIFO_WIDTH     = 8;
   localparam int          FIFO_DEPTH     = 4;
endpackage : mb_write_pkg

// *** design/modbus_multi_register_write.sv ***
// function 0x10 interpreter with its reply fifo
`timescale 1ns/1ps
`default_nettype none

module mb_byte_fifo #(
   parameter int W = 8,
   parameter int D = 4
) (
   input  wire logic         clk_i,
   input  wire logic         rst_n_i,
   input  wire logic [W-1:0] in_data_i,
   input  wire logic         in_valid_i,
   output logic              in_ready_o,
   output logic [W-1:0]      out_data_o,
   output logic              out_valid_o,
   input  wire logic         out_ready_i
);
   // head always sits in slot 0 so the outputs come straight off flops
   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [D-1:0]        vld;
   } fifo_s;

   fifo_s r_reg;
   fifo_s r_next;

   assign in_ready_o  = ~r_reg.vld[D-1];
   assign out_data_o  = r_reg.mem[0];
   assign out_valid_o = r_reg.vld[0];

   always_comb begin
      logic placed;
      placed = 1'b0;
      r_next = r_reg;
      if (r_reg.vld[0] && out_ready_i) begin
         for (int i = 0; i < D - 1; i++) begin
            r_next.mem[i] = r_reg.mem[i+1];
            r_next.vld[i] = r_reg.vld[i+1];
         end
         r_next.vld[D-1] = 1'b0;
      end
      if (in_valid_i && ~r_reg.vld[D-1]) begin
         for (int i = 0; i < D; i++) begin
            if (!placed && !r_next.vld[i]) begin
               r_next.mem[i] = in_data_i;
               r_next.vld[i] = 1'b1;
               placed        = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end
endmodule : mb_byte_fifo

module modbus_multi_register_write (
   input  wire logic                  core_clk_i,
   input  wire logic                  rst_n_i,
   input  wire logic [7:0]            slave_addr_i,
   input  wire logic [7:0]            rx_data_i,
   input  wire logic                  rx_valid_i,
   input  wire logic                  rx_end_i,
   output logic [7:0]                 tx_data_o,
   output logic                       tx_valid_o,
   input  wire logic                  tx_ready_i,
   output logic [15:0]                drive_control_word_o,
   output logic [15:0]                general_control_word_o,
   output logic [15:0]                speed_setpoint_o,
   output logic                       run_cmd_o,
   output logic                       write_done_o
);
   import mb_write_pkg::*;

   typedef enum logic {PH_RX, PH_TX} phase_e;

   typedef struct packed {
      phase_e                     phase;
      logic [7:0]                 idx;
      logic [15:0]                crc;
      logic [7:0]                 dev;
      logic [7:0]                 fc;
      logic [15:0]                start;
      logic [15:0]                qty;
      logic [7:0]                 bc;
      logic [PD_COUNT-1:0][15:0]  stage;
      logic [PD_COUNT-1:0][15:0]  pd;
      logic                       run;
      logic [15:0]                speed;
      logic                       done;
      logic [2:0]                 tx_idx;
   } state_s;

   state_s     r_reg;
   state_s     r_next;
   logic [1:0] rst_sync_reg;
   logic       rst_n;
   logic       push;
   logic [7:0] push_data;
   logic       fifo_in_ready;

   function automatic logic [15:0] crc_step(input logic [15:0] c,
                                            input logic [7:0]  b);
      logic [15:0] v;
      v = c ^ {8'h00, b};
      for (int k = 0; k < 8; k++) begin
         v = v[0] ? ((v >> 1) ^ CRC_POLY) : (v >> 1);
      end
      return v;
   endfunction : crc_step

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_sync_reg <= 2'h0;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_reg[1];

   // frame checks use only bytes already captured
   logic [15:0] off;
   logic [7:0]  frame_len;
   logic        addr_ok;
   logic        frame_ok;
   assign off       = r_reg.start - PD_BASE;
   assign frame_len = IDX_DATA + r_reg.bc + CRC_LEN;
   assign addr_ok   = (r_reg.dev == slave_addr_i) || (r_reg.dev == BCAST_ADDR);
   assign frame_ok  = addr_ok && (r_reg.fc == FC_WRITE_MULTI)
      && (r_reg.crc == CRC_RESIDUE)
      && (r_reg.idx == frame_len)
      && (r_reg.qty[15:8] == 8'h00)
      && (r_reg.bc == {r_reg.qty[6:0], 1'b0})
      && !r_reg.qty[7]
      && (r_reg.qty != 16'h0000)
      && (r_reg.start >= PD_BASE)
      && (off + r_reg.qty <= PD_COUNT_W);

   always_comb begin
      logic [7:0] rel;
      logic [6:0] slot;
      rel       = r_reg.idx - IDX_DATA;
      slot      = rel[7:1];
      r_next    = r_reg;
      r_next.done = 1'b0;
      push      = 1'b0;
      push_data = 8'h00;
      unique case (r_reg.phase)
         PH_RX: begin
            if (rx_end_i) begin
               r_next.idx = 8'h00;
               r_next.crc = CRC_INIT;
               if (frame_ok) begin
                  // staged values land only now, after the checks
                  for (int i = 0; i < PD_COUNT; i++) begin
                     if (16'(i) < r_reg.qty) begin
                        r_next.pd[2'(off[1:0] + 2'(i))] =
                           r_reg.stage[i];
                     end
                  end
                  r_next.done   = 1'b1;
                  r_next.tx_idx = 3'h0;
                  if (r_reg.dev != BCAST_ADDR) begin
                     r_next.phase = PH_TX;
                  end
               end
            end else if (rx_valid_i) begin
               r_next.crc = crc_step(r_reg.crc, rx_data_i);
               if (r_reg.idx != IDX_MAX) begin
                  r_next.idx = r_reg.idx + 8'h01;
               end
               unique case (r_reg.idx)
                  IDX_DEV:      r_next.dev         = rx_data_i;
                  IDX_FC:       r_next.fc          = rx_data_i;
                  // address already carries the minus-one offset
                  IDX_START_HI: r_next.start[15:8] = rx_data_i;
                  IDX_START_LO: r_next.start[7:0]  = rx_data_i;
                  IDX_QTY_HI:   r_next.qty[15:8]   = rx_data_i;
                  IDX_QTY_LO:   r_next.qty[7:0]    = rx_data_i;
                  IDX_BC:       r_next.bc          = rx_data_i;
                  default: begin
                     // crc bytes also land here; the slot bound drops them, or for qty below 3 the qty check at commit ignores them
                     if (r_reg.idx >= IDX_DATA && 32'(slot) < PD_COUNT) begin
                        if (!rel[0]) begin
                           r_next.stage[slot[1:0]][15:8] = rx_data_i;
                        end else begin
                           r_next.stage[slot[1:0]][7:0] = rx_data_i;
                        end
                     end
                  end
               endcase
            end
         end
         PH_TX: begin
            // reply stalls here while the fifo is full
            if (fifo_in_ready) begin
               push = 1'b1;
               unique case (r_reg.tx_idx)
                  3'h0: push_data = r_reg.dev;
                  3'h1: push_data = r_reg.fc;
                  3'h2: push_data = r_reg.start[15:8];
                  3'h3: push_data = r_reg.start[7:0];
                  3'h4: push_data = r_reg.qty[15:8];
                  3'h5: push_data = r_reg.qty[7:0];
                  3'h6: push_data = r_reg.crc[7:0];
                  3'h7: push_data = r_reg.crc[15:8];
               endcase
               if (r_reg.tx_idx < RSP_CRC_LO) begin
                  r_next.crc = crc_step(r_reg.crc, push_data);
               end
               r_next.tx_idx = r_reg.tx_idx + 3'h1;
               if (r_reg.tx_idx == RSP_LAST) begin
                  r_next.phase = PH_RX;
                  r_next.crc   = CRC_INIT;
               end
            end
         end
      endcase
      r_next.run   = (r_next.pd[PD_CTRL] == RUN_CMD);
      // hundredths of a percent, capped at full scale
      r_next.speed = (r_next.pd[PD_SPEED] > SETPOINT_FULL)
                     ? SETPOINT_FULL : r_next.pd[PD_SPEED];
   end

   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         r_reg       <= '0;
         r_reg.phase <= PH_RX;
         r_reg.crc   <= CRC_INIT;
      end else begin
         r_reg <= r_next;
      end
   end

   // general control word is kept for readback only
   assign drive_control_word_o   = r_reg.pd[PD_CTRL];
   assign general_control_word_o = r_reg.pd[1];
   assign speed_setpoint_o       = r_reg.speed;
   assign run_cmd_o              = r_reg.run;
   assign write_done_o           = r_reg.done;

   mb_byte_fifo #(
      .W (FIFO_WIDTH),
      .D (FIFO_DEPTH)
   ) u_reply_fifo (
      .clk_i       (core_clk_i),
      .rst_n_i     (rst_n),
      .in_data_i   (push_data),
      .in_valid_i  (push),
      .in_ready_o  (fifo_in_ready),
      .out_data_o  (tx_data_o),
      .out_valid_o (tx_valid_o),
      .out_ready_i (tx_ready_i)
   );
endmodule : modbus_multi_register_write

`default_nettype wire

// *** bench/mb_master_model.sv ***
// fieldbus master model: takes reply bytes with long stalls
`timescale 1ns/1ps
`default_nettype none
module mb_master_model (
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   input  wire logic [7:0] tx_data_i,
   input  wire logic       tx_valid_i,
   output logic            tx_ready_o,
   output logic [7:0]      got_data_o,
   output logic            got_o
);
   logic [1:0] ph_reg;
   // one take in four cycles so the reply fifo fills and pushes stall
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) ph_reg <= 2'h0;
      else ph_reg <= ph_reg + 2'h1;
   end
   assign tx_ready_o = (ph_reg == 2'h3);
   assign got_o      = tx_valid_i && tx_ready_o;
   assign got_data_o = tx_data_i;
endmodule : mb_master_model
`default_nettype wire

// *** bench/mb_write_monitor.sv ***
// assertion checker for the multi-register write block
`timescale 1ns/1ps
`default_nettype none
module mb_write_monitor (
   input wire logic        core_clk_i,
   input wire logic        rst_n_i,
   input wire logic        rx_end_i,
   input wire logic [7:0]  tx_data_o,
   input wire logic        tx_valid_o,
   input wire logic        tx_ready_i,
   input wire logic [15:0] drive_control_word_o,
   input wire logic [15:0] general_control_word_o,
   input wire logic [15:0] speed_setpoint_o,
   input wire logic        run_cmd_o,
   input wire logic        write_done_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   property p_run; run_cmd_o == (drive_control_word_o == 16'h0001);
   endproperty
   a_run: assert property (p_run) else $error("run flag wrong");
   property p_spd; speed_setpoint_o <= 16'h2710; endproperty
   a_spd: assert property (p_spd) else $error("setpoint too big");
   property p_ctl; !write_done_o |-> $stable(drive_control_word_o);
   endproperty
   a_ctl: assert property (p_ctl) else $error("ctrl moved");
   property p_gen; !write_done_o |-> $stable(general_control_word_o);
   endproperty
   a_gen: assert property (p_gen) else $error("general moved");
   property p_sps; !write_done_o |-> $stable(speed_setpoint_o); endproperty
   a_sps: assert property (p_sps) else $error("speed moved");
   property p_pls; write_done_o |=> !write_done_o; endproperty
   a_pls: assert property (p_pls) else $error("done too long");
   property p_src; write_done_o |-> $past(rx_end_i); endproperty
   a_src: assert property (p_src) else $error("done without end");
   property p_hold; tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o);
   endproperty
   a_hold: assert property (p_hold) else $error("reply byte lost");
   property p_excl; write_done_o |-> !tx_valid_o; endproperty
   a_excl: assert property (p_excl) else $error("reply too early");
   c_done: cover property (write_done_o);
   c_stall: cover property (tx_valid_o && !tx_ready_i);
   c_run: cover property (run_cmd_o);
endmodule : mb_write_monitor
bind modbus_multi_register_write mb_write_monitor u_mon (.core_clk_i,
   .rst_n_i, .rx_end_i, .tx_data_o, .tx_valid_o, .tx_ready_i,
   .drive_control_word_o, .general_control_word_o, .speed_setpoint_o,
   .run_cmd_o, .write_done_o);
`default_nettype wire

// *** bench/tb_modbus_multi_register_write.sv ***
// self-checking bench for the multi-register write block
`timescale 1ns/1ps
`default_nettype none
module tb_modbus_multi_register_write;
   import mb_write_pkg::*;
   logic core_clk_i = 1'b0, rst_n_i = 1'b0, rx_valid_i = 1'b0, rx_end_i = 1'b0;
   logic [7:0]  slave_addr_i = 8'h05, rx_data_i = 8'h00, tx_data_o, got_d;
   logic        tx_valid_o, tx_ready_i, run_cmd_o, write_done_o, got;
   logic [15:0] drive_control_word_o, general_control_word_o, speed_setpoint_o;
   logic [15:0] ex[3] = '{16'h0, 16'h0, 16'h0}, dv[4];
   logic [7:0]  fr[$], rq[$], eq[$];
   int error_cnt = 0, cmp_count = 0, seed = 43, done_n = 0, exp_done = 0;
   always #10 core_clk_i = ~core_clk_i;
   modbus_multi_register_write u_dut (.core_clk_i, .rst_n_i, .slave_addr_i,
      .rx_data_i, .rx_valid_i, .rx_end_i, .tx_data_o, .tx_valid_o, .tx_ready_i,
      .drive_control_word_o, .general_control_word_o, .speed_setpoint_o,
      .run_cmd_o, .write_done_o);
   mb_master_model u_master (.clk_i(core_clk_i), .rst_n_i, .tx_data_i(tx_data_o),
      .tx_valid_i(tx_valid_o), .tx_ready_o(tx_ready_i), .got_data_o(got_d),
      .got_o(got));
   always @(posedge core_clk_i) begin
      if (got === 1'b1) rq.push_back(got_d);
      if (write_done_o === 1'b1) done_n++;
   end
   function automatic logic [15:0] crc16(input logic [7:0] q[$]);
      logic [15:0] c;
      c = CRC_INIT;
      foreach (q[i]) begin
         c ^= {8'h00, q[i]};
         repeat (8) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
      end
      return c;
   endfunction : crc16
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      cmp_count++;
      if (g !== e) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic conclude;
      if (error_cnt == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : conclude
   task automatic send(input logic [7:0] dev, input logic [15:0] st, qty,
                       input logic [7:0] bc, input bit bad);
      logic [15:0] c;
      bit ok;
      fr = {dev, FC_WRITE_MULTI, st[15:8], st[7:0], qty[15:8], qty[7:0], bc};
      for (int i = 0; i < bc; i++) fr.push_back(i[0] ? dv[i/2][7:0] : dv[i/2][15:8]);
      c = crc16(fr) ^ (bad ? 16'h0100 : 16'h0000);
      fr.push_back(c[7:0]);
      fr.push_back(c[15:8]);
      ok = (dev == slave_addr_i || dev == BCAST_ADDR) && bc == 2 * qty && !bad
           && qty >= 1 && qty <= 3 && st >= PD_BASE && st + qty <= PD_BASE + 3;
      foreach (fr[i]) begin
         @(posedge core_clk_i) #2;
         rx_valid_i = 1'b1;
         rx_data_i  = fr[i];
      end
      @(posedge core_clk_i) #2;
      rx_valid_i = 1'b0;
      rx_end_i   = 1'b1;
      @(posedge core_clk_i) #2;
      rx_end_i = 1'b0;
      if (ok) begin
         for (int i = 0; i < qty; i++) ex[st - PD_BASE + i] = dv[i];
         exp_done++;
         if (dev != BCAST_ADDR) begin
            eq = {dev, FC_WRITE_MULTI, st[15:8], st[7:0], qty[15:8], qty[7:0]};
            c = crc16(eq);
            eq.push_back(c[7:0]);
            eq.push_back(c[15:8]);
         end
      end
      // long enough for eight stalled reply bytes
      repeat (80) @(posedge core_clk_i);
      chk("reply length", eq.size(), rq.size());
      foreach (eq[i]) chk("reply byte", eq[i], rq[i]);
      chk("ctrl word", ex[0], drive_control_word_o);
      chk("general word", ex[1], general_control_word_o);
      chk("speed", ex[2] > SETPOINT_FULL ? SETPOINT_FULL : ex[2],
          speed_setpoint_o);
      chk("run", ex[0] == RUN_CMD, run_cmd_o);
      chk("done count", exp_done, done_n);
      eq.delete();
      rq.delete();
   endtask : send
   initial begin
      logic [31:0] r;
      repeat (6) @(posedge core_clk_i);
      #2 rst_n_i = 1'b1;
      repeat (3) @(posedge core_clk_i);
      dv = '{16'h0001, 16'h0000, 16'h2710, 16'h0000};
      send(8'h05, 16'h07d0, 16'h0003, 8'h06, 1'b0);
      for (int k = 0; k < 24; k++) begin
         r = $random(seed);
         foreach (dv[i]) dv[i] = $random(seed);
         send(r[1:0] == 2'h0 ? BCAST_ADDR : r[1:0] == 2'h3 ? 8'h07 : 8'h05,
              PD_BASE - 16'h1 + r[3:2], {14'h0, r[5:4]},
              {5'h0, r[5:4], r[8:6] == 3'h0}, r[11:9] == 3'h0);
      end
      conclude();
   end
endmodule : tb_modbus_multi_register_write
`default_nettype wire
